// [design/btse_addr_resolve.sv]
`timescale 1ns/1ps
module btse_addr_resolve (
	// Operand fields
	input  wire logic                  accessFlag,
	input  wire logic [7:0]            fileAddr,
	// Context
	input  wire logic [3:0]            bank_select_reg,
	input  wire logic                  extendedEn,
	input  wire logic [11:0]           indexBase,
	// Result
	output logic [11:0]                physAddr,
	output btse_pkg::btse_mode_t       addrMode
);
	wire idxHit  = ~accessFlag & extendedEn & (fileAddr <= btse_pkg::IDX_LIMIT);
	wire accLow  = fileAddr < btse_pkg::ACC_SPLIT;
	wire [3:0] accBank = accLow ? btse_pkg::ACC_LOW_BANK : btse_pkg::ACC_HIGH_BANK;
	wire [11:0] idxAddr = indexBase + {4'h0, fileAddr};

	// Indexed form wins over plain access bank only when extended set is on
	assign addrMode = idxHit ? btse_pkg::BTSE_MODE_INDEXED :
		(accessFlag ? btse_pkg::BTSE_MODE_BANKED : btse_pkg::BTSE_MODE_ACCESS);
	assign physAddr = idxHit ? idxAddr :
		(accessFlag ? {bank_select_reg, fileAddr} :
		{accBank, fileAddr});
endmodule : btse_addr_resolve

// [design/btse_core.sv]
`timescale 1ns/1ps
// Function
// - Skip-if-set variant skips the next instruction when the tested bit is one.
// - A taken skip replaces the fetched next instruction with a no-operation.
// - Access flag zero resolves the file operand in the fixed access bank.
// - Access flag one uses the bank select register to pick the bank.
// - Access zero with extended set: addresses up to 95 use indexed offset.
module btse_core (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	// Instruction stream
	input  wire logic [15:0] instrWord,
	input  wire logic [15:0] nextWord,
	input  wire logic        instrValid,
	// Addressing context
	input  wire logic [3:0]  bank_select_reg,
	input  wire logic        extendedEn,
	input  wire logic [11:0] indexBase,
	// Data memory read port
	output logic [11:0]      memAddr,
	output logic             memRd,
	input  wire logic [7:0]  memData,
	// Results
	output logic [1:0]       phase,
	output logic             isBitTest,
	output logic [1:0]       addrMode,
	output logic             skipTaken,
	output logic [15:0]      execWord,
	output logic             busy
);
	// ****************************************
	// Decode
	// ****************************************
	function automatic logic [1:0] opClass(input logic [15:0] w);
		logic [3:0] op;
		op = w[btse_pkg::OPC_MSB:btse_pkg::OPC_LSB];
		opClass = {op == btse_pkg::OPC_SKIP_SET, op == btse_pkg::OPC_SKIP_CLR};
	endfunction : opClass

	btse_pkg::btse_phase_t phase_r, phase_nxt;
	logic [15:0]           instr_r;
	logic                  inTest_r;
	logic                  flush_r;
	logic [11:0]           addr_r;
	logic [1:0]            mode_r;
	logic                  rd_r;
	logic                  skip_r;
	logic [15:0]           exec_r;

	wire [1:0]  curClass  = opClass(instr_r);
	wire        curIsSet  = curClass[1];
	wire        curIsClr  = curClass[0];
	wire        newTest   = instrValid & (|opClass(instrWord));
	wire        accFlag   = instrWord[btse_pkg::ACC_POS];
	wire [7:0]  newFile   = instrWord[btse_pkg::FILE_MSB:btse_pkg::FILE_LSB];
	wire [2:0]  bitSel    = instr_r[btse_pkg::BIT_MSB:btse_pkg::BIT_LSB];
	wire [7:0]  bitHit;
	wire        testedBit = |bitHit;
	wire        skipNow   = (curIsSet & testedBit)
		| (curIsClr & ~testedBit);
	wire [11:0]           resAddr;
	btse_pkg::btse_mode_t resMode;

	// One lane per data bit; a one passes only on the selected lane
	for (genvar i = 0; i < 8; i++) begin : g_bitPick
		assign bitHit[i] = memData[i] & (bitSel == 3'(i));
	end

	btse_addr_resolve u_resolve (
		.accessFlag      (accFlag),
		.fileAddr        (newFile),
		.bank_select_reg (bank_select_reg),
		.extendedEn      (extendedEn),
		.indexBase       (indexBase),
		.physAddr        (resAddr),
		.addrMode        (resMode)
	);

	// ****************************************
	// Phase sequencer
	// ****************************************
	always_comb begin
		unique case (phase_r)
			btse_pkg::BTSE_Q1: phase_nxt = btse_pkg::BTSE_Q2;
			btse_pkg::BTSE_Q2: phase_nxt = btse_pkg::BTSE_Q3;
			btse_pkg::BTSE_Q3: phase_nxt = btse_pkg::BTSE_Q4;
			btse_pkg::BTSE_Q4: phase_nxt = btse_pkg::BTSE_Q1;
		endcase
	end

	wire atQ1 = phase_r == btse_pkg::BTSE_Q1;
	wire atQ2 = phase_r == btse_pkg::BTSE_Q2;
	wire atQ3 = phase_r == btse_pkg::BTSE_Q3;
	wire atQ4 = phase_r == btse_pkg::BTSE_Q4;

	wire rdNxt    = atQ1 & inTest_r;
	wire skipNxt  = atQ3 & inTest_r & skipNow;
	wire flushNxt = inTest_r & skipNow;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_r <= btse_pkg::BTSE_Q1;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// ****************************************
	// Elaboration checks
	// ****************************************
	// Decoder assumes a four-bit opcode at the top of a 16-bit word
	if (btse_pkg::OPC_MSB != 15 || btse_pkg::OPC_MSB - btse_pkg::OPC_LSB != 3) begin : g_badOpcode
		$error("Opcode field must be the top four bits of the word");
	end
	if (btse_pkg::BIT_MSB - btse_pkg::BIT_LSB != 2) begin : g_badBitField
		$error("Bit index field must be three bits wide");
	end
	if (btse_pkg::FILE_MSB - btse_pkg::FILE_LSB != 7) begin : g_badFileField
		$error("File address field must be eight bits wide");
	end
	// Both variants share one decoder, so their codes must differ
	if (btse_pkg::OPC_SKIP_SET == btse_pkg::OPC_SKIP_CLR) begin : g_badVariants
		$error("Skip variants need distinct opcodes");
	end
	// Indexed window must sit below the access bank split
	if (btse_pkg::IDX_LIMIT >= btse_pkg::ACC_SPLIT) begin : g_badSplit
		$error("Indexed window overlaps the upper access bank");
	end

	// ****************************************
	// Execute
	// ****************************************
	// Instruction latched at the Q4 edge; memory read issued in Q2, sampled in Q3
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			instr_r <= btse_pkg::NOP_WORD;
		end else if (atQ4) begin
			// A flushed slot never starts a test of its own
			instr_r <= flush_r ? btse_pkg::NOP_WORD : instrWord;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			inTest_r <= 1'b0;
		end else if (atQ4) begin
			inTest_r <= newTest & ~flush_r;
		end
	end

	// Resolved from the incoming word so the Q2 read needs no extra clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			addr_r <= btse_pkg::ADDR_RST;
		end else if (atQ4) begin
			addr_r <= resAddr;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= btse_pkg::BTSE_MODE_ACCESS;
		end else if (atQ4) begin
			mode_r <= resMode;
		end
	end

	// Read strobe covers Q2 only
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_r <= 1'b0;
		end else begin
			rd_r <= rdNxt;
		end
	end

	// ****************************************
	// Skip and flush
	// ****************************************
	// One-clock pulse through Q4 of the test slot
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			skip_r <= 1'b0;
		end else begin
			skip_r <= skipNxt;
		end
	end

	// Flag lives from the Q3 decision until the flushed slot's own Q3
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flush_r <= 1'b0;
		end else if (atQ3) begin
			flush_r <= flushNxt;
		end
	end

	// Word handed on to the rest of the core; NOP in place of the skipped one
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			exec_r <= btse_pkg::NOP_WORD;
		end else if (atQ4) begin
			exec_r <= flush_r ? btse_pkg::NOP_WORD : nextWord;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign phase     = phase_r;
	assign isBitTest = inTest_r;
	assign addrMode  = mode_r;
	assign memAddr   = addr_r;
	assign memRd     = rd_r;
	assign skipTaken = skip_r;
	assign execWord  = exec_r;
	assign busy      = flush_r;
endmodule : btse_core

// [shared/btse_pkg.sv]
package btse_pkg;
	// ****************************************
	// Opcode fields
	// ****************************************
	localparam int          OPC_MSB       = 15;
	localparam int          OPC_LSB       = 12;
	localparam int          BIT_MSB       = 11;
	localparam int          BIT_LSB       = 9;
	localparam int          ACC_POS       = 8;
	localparam int          FILE_MSB      = 7;
	localparam int          FILE_LSB      = 0;
	localparam logic [3:0]  OPC_SKIP_CLR  = 4'hb;
	localparam logic [3:0]  OPC_SKIP_SET  = 4'ha;
	localparam logic [15:0] NOP_WORD      = 16'h0000;
	// ****************************************
	// Addressing
	// ****************************************
	localparam logic [7:0]  IDX_LIMIT     = 8'h5f;
	localparam logic [7:0]  ACC_SPLIT     = 8'h60;
	localparam logic [3:0]  ACC_LOW_BANK  = 4'h0;
	localparam logic [3:0]  ACC_HIGH_BANK = 4'hf;
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [1:0]  PHASE_RST     = 2'h0;
	localparam logic [11:0] ADDR_RST      = 12'h000;

	typedef enum logic [1:0] {
		BTSE_Q1 = 2'b00,
		BTSE_Q2 = 2'b01,
		BTSE_Q3 = 2'b10,
		BTSE_Q4 = 2'b11
	} btse_phase_t;

	typedef enum logic [1:0] {
		BTSE_MODE_ACCESS  = 2'b00,
		BTSE_MODE_BANKED  = 2'b01,
		BTSE_MODE_INDEXED = 2'b10
	} btse_mode_t;
endpackage : btse_pkg

// [test/btse_core_checker.sv]
`timescale 1ns/1ps
module btse_core_checker (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst_b,
	// Stimulus seen
	input wire logic [15:0] instrWord,
	input wire logic [7:0]  memData,
	input wire logic [3:0]  bank_select_reg,
	input wire logic        extendedEn,
	input wire logic [11:0] indexBase,
	// Results
	input wire logic [11:0] memAddr,
	input wire logic [1:0]  phase,
	input wire logic        isBitTest,
	input wire logic [1:0]  addrMode,
	input wire logic        skipTaken,
	input wire logic [15:0] execWord,
	input wire logic        memRd,
	input wire logic        busy
);
	// ****************************************
	// Decode helpers
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Bench holds operands for the slot, so Q3 values are one edge back at Q4
	wire logic [7:0] f    = instrWord[7:0];
	wire logic       tbit = memData[instrWord[11:9]];
	wire logic       dec  = isBitTest && phase == 2'h1;
	wire logic       low  = extendedEn && f <= 8'h5f;
	wire logic       q4   = isBitTest && phase == 2'h3;

	AST_SKIP_SET: assert property (q4 && $past(instrWord[15:12]) == 4'ha |->
		skipTaken == $past(tbit)) else $error("set test skip wrong");
	AST_SKIP_CLR: assert property (q4 && $past(instrWord[15:12]) == 4'hb |->
		skipTaken == !$past(tbit)) else $error("clear test skip wrong");
	AST_FLUSH: assert property (skipTaken |=> execWord == 16'h0000 && !isBitTest)
		else $error("skipped word not flushed");
	AST_ACCESS: assert property (dec && !instrWord[8] && !low |-> addrMode == 2'h0 &&
		memAddr == {(f < 8'h60) ? 4'h0 : 4'hf, f}) else $error("access bank wrong");
	AST_BANKED: assert property (dec && instrWord[8] |-> addrMode == 2'h1 &&
		memAddr == {bank_select_reg, f}) else $error("banked address wrong");
	AST_INDEXED: assert property (dec && !instrWord[8] && low |-> addrMode == 2'h2 &&
		memAddr == indexBase + {4'h0, f}) else $error("indexed address wrong");
	AST_READ_Q2: assert property (memRd == dec)
		else $error("read strobe outside Q2 of a test");
	AST_SKIP_SLOT: assert property (skipTaken |-> q4)
		else $error("skip pulse outside Q4 of a test");
	AST_BUSY_SPAN: assert property (skipTaken |-> busy[*4] ##1 !busy)
		else $error("flush window has wrong length");
endmodule : btse_core_checker

bind btse_core btse_core_checker btse_core_checker_inst (.clk, .rst_b, .instrWord, .memData,
	.bank_select_reg, .extendedEn, .indexBase, .memAddr, .phase, .isBitTest, .addrMode,
	.skipTaken, .execWord, .memRd, .busy);

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
	// ****************************************
	// Stimulus and capture
	// ****************************************
	logic        clk = 1'h0, rst_b = 1'h0, instrValid = 1'h1, extendedEn = 1'h0;
	logic        isBitTest, skipTaken, sk, memRd, busy, mr, bz;
	logic [15:0] instrWord = 16'h0000, nextWord = 16'h0000, execWord, ew;
	logic [3:0]  bank_select_reg = 4'h0;
	logic [11:0] indexBase = 12'h200, memAddr, ma;
	logic [7:0]  memData = 8'h00;
	logic [1:0]  phase, addrMode, am;
	int          num_errors = 0, checks = 0;

	btse_core btse_core_inst (.clk, .rst_b, .instrWord, .nextWord, .instrValid, .bank_select_reg,
		.extendedEn, .indexBase, .memAddr, .memRd, .memData, .phase, .isBitTest, .addrMode,
		.skipTaken, .execWord, .busy);

	initial forever #10 clk = ~clk;

	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : end_of_test

	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// Drives in Q4; execWord seen in Q1 belongs to the previous slot
	task automatic issue(logic [15:0] w, logic [15:0] n, logic [7:0] d);
		while (phase !== 2'h3) @(negedge clk);
		instrWord = w;
		nextWord = n;
		memData = d;
		@(negedge clk);
		while (phase !== 2'h0) @(negedge clk);
		ew = execWord;
		ma = memAddr;
		am = addrMode;
		@(negedge clk);
		mr = memRd;
		while (phase !== 2'h3) @(negedge clk);
		sk = skipTaken;
		bz = busy;
	endtask : issue

	// Second word is itself a test, so a flushed slot must not test
	task automatic t_skip(logic [3:0] op, logic [7:0] d, logic e);
		logic [15:0] w;
		w = {op, 3'h5, 1'h1, 8'h20};
		issue(w, w, d);
		chk("skip", e, sk);
		chk("read", 1'h1, mr);
		chk("busy", e, bz);
		issue(w, 16'h5678, d);
		chk("exec", e ? 16'h0000 : 16'h5678, ew);
		chk("refused", 1'h0, sk);
		chk("flushed read", !e, mr);
		chk("busy end", 1'h0, bz);
	endtask : t_skip

	// Test opcode without its valid qualifier must not start a test
	task automatic t_invalid();
		instrValid = 1'h0;
		issue(16'hab20, 16'h1111, 8'h20);
		chk("invalid skip", 1'h0, sk);
		chk("invalid read", 1'h0, mr);
		instrValid = 1'h1;
	endtask : t_invalid

	task automatic t_addr(logic a, logic x, logic [7:0] f, logic [1:0] m, logic [11:0] p);
		extendedEn = x;
		bank_select_reg = 4'h3;
		issue({4'ha, 3'h0, a, f}, 16'h0000, 8'h00);
		chk("mode", m, am);
		chk("addr", p, ma);
		chk("read", 1'h1, mr);
	endtask : t_addr

	initial begin
		repeat (20) @(negedge clk);
		rst_b = 1'h1;
		t_skip(4'ha, 8'h20, 1'h1);
		t_skip(4'ha, 8'hdf, 1'h0);
		t_skip(4'hb, 8'hdf, 1'h1);
		t_skip(4'hb, 8'h20, 1'h0);
		t_invalid();
		t_addr(1'h1, 1'h0, 8'h10, 2'h1, 12'h310);
		t_addr(1'h0, 1'h0, 8'h5f, 2'h0, 12'h05f);
		t_addr(1'h0, 1'h1, 8'h5f, 2'h2, 12'h25f);
		t_addr(1'h0, 1'h1, 8'h60, 2'h0, 12'hf60);
		end_of_test();
	end

	// About 75 cycles of work; over ten times that before giving up
	initial begin
		#20000;
		num_errors++;
		end_of_test();
	end
endmodule : testbench
